// ---- src/rilcfg_pkg.sv ----
package rilcfg_pkg;

	// Divider from the core clock to the serial clock
	localparam int unsigned DIV_RATIO = 256;

	// Cycles the select line floats before it is sensed
	localparam int unsigned SENSE_CYC = 4;
	localparam int unsigned SENSE_W   = 3;

	// Serial read command, word organisation
	localparam logic [2:0] CMD_READ = 3'h6;
	localparam int unsigned CMD_W   = 3;
	localparam int unsigned ADDR_W  = 6;
	localparam int unsigned WORD_W  = 16;
	localparam int unsigned HDR_BITS = 9;
	localparam int unsigned SEQ_LEN  = 25;
	localparam int unsigned SEQ_W    = 5;

	// Stored words, in load order
	localparam int unsigned NUM_WORDS = 4;
	localparam int unsigned IDX_W     = 2;
	localparam logic [ADDR_W-1:0] ADDR_VENDOR     = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_MODEL      = 6'h01;
	localparam logic [ADDR_W-1:0] ADDR_SUB_VENDOR = 6'h02;
	localparam logic [ADDR_W-1:0] ADDR_PRODUCT    = 6'h03;

	typedef enum logic [2:0] {
		ST_SENSE  = 3'b000,
		ST_SELECT = 3'b001,
		ST_READ   = 3'b010,
		ST_GAP    = 3'b011,
		ST_DONE   = 3'b100
	} rilcfg_state_t;

	typedef struct packed {
		logic clock;
		logic select;
		logic write;
	} rilcfg_port_wr_t;

	typedef struct packed {
		logic present;
		logic loading;
		logic read_line;
		logic write;
		logic select;
		logic clock;
	} rilcfg_port_rd_t;

	typedef struct packed {
		logic [WORD_W-1:0] vendor;
		logic [WORD_W-1:0] model;
		logic [WORD_W-1:0] sub_vendor;
		logic [WORD_W-1:0] product;
	} rilcfg_id_t;

endpackage : rilcfg_pkg

// ---- src/rilcfg_tick_div.sv ----
module rilcfg_tick_div #(
	parameter int unsigned DIV = rilcfg_pkg::DIV_RATIO
) (
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	input  wire logic en_i,
	output logic      tick_o
);

	// One pulse per half serial clock period
	localparam int unsigned HALF = DIV / 2;
	localparam int unsigned CW   = $clog2(HALF);
	localparam logic [CW-1:0] LAST = CW'(HALF - 1);

	logic [CW-1:0] cnt_reg;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= '0;
		end else if (!en_i || cnt_reg == LAST) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	assign tick_o = en_i && cnt_reg == LAST;

endmodule : rilcfg_tick_div

// ---- src/rilcfg_word_reader.sv ----
module rilcfg_word_reader (
	input  wire logic                            core_clk_i,
	input  wire logic                            rst_b_i,
	input  wire logic                            tick_i,
	input  wire logic                            start_i,
	input  wire logic [rilcfg_pkg::ADDR_W-1:0]   addr_i,
	input  wire logic                            read_line_i,
	output logic                                 sclk_o,
	output logic                                 write_line_o,
	output logic                                 busy_o,
	output logic                                 done_o,
	output logic [rilcfg_pkg::WORD_W-1:0]        data_o
);

	localparam int unsigned HW = rilcfg_pkg::HDR_BITS;
	localparam logic [rilcfg_pkg::SEQ_W-1:0] HDR_END = rilcfg_pkg::SEQ_W'(HW - 1);
	localparam logic [rilcfg_pkg::SEQ_W-1:0] SEQ_END = rilcfg_pkg::SEQ_W'(rilcfg_pkg::SEQ_LEN - 1);

	logic [HW-1:0]                   hdr_reg;
	logic [rilcfg_pkg::SEQ_W-1:0]    bit_reg;

	// Start bit, opcode and address go out MSB first; data follows the dummy zero
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_o       <= 1'b0;
			done_o       <= 1'b0;
			sclk_o       <= 1'b0;
			write_line_o <= 1'b0;
			bit_reg      <= '0;
			hdr_reg      <= '0;
			data_o       <= '0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				busy_o       <= 1'b1;
				bit_reg      <= '0;
				hdr_reg      <= {rilcfg_pkg::CMD_READ, addr_i} << 1;
				write_line_o <= rilcfg_pkg::CMD_READ[rilcfg_pkg::CMD_W-1];
			end else if (busy_o && tick_i) begin
				sclk_o <= !sclk_o;
				if (sclk_o) begin
					if (bit_reg >= HDR_END) begin
						data_o <= {data_o[rilcfg_pkg::WORD_W-2:0], read_line_i};
					end
					write_line_o <= (bit_reg < HDR_END) ? hdr_reg[HW-1] : 1'b0;
					hdr_reg      <= hdr_reg << 1;
					bit_reg      <= bit_reg + 1'b1;
					if (bit_reg == SEQ_END) begin
						busy_o <= 1'b0;
						done_o <= 1'b1;
					end
				end
			end
		end
	end

endmodule : rilcfg_word_reader

// ---- src/rilcfg_loader.sv ----
// Function
// - During reset loading the serial clock is the core clock divided by 256.
// - Outside the load, software toggles the serial clock through the port control.
// - Software sets and clears the chip select through the port control.
// - At power up the pulled-up chip select level tells whether a memory is attached.
// - Software drives the write line through the port control.
// - The loader reads the memory in 16-bit word organisation, one word per item.
// - The read line level is visible to software through the port control.
// - The sampled infrared strap is copied into modem control bit 6 of both channels.
// - The infrared strap is sampled at power up, hardware reset and soft reset.
// - A high half-duplex strap at reset sets feature control bit 5 in both channels.
// - Software writes to the half-duplex bit override the strap after reset.
// - The loaded words are vendor, model, sub-vendor and product identifiers.
// - Loaded identification is used only when a memory is present.
module rilcfg_loader #(
	parameter int unsigned                        DIV_RATIO      = rilcfg_pkg::DIV_RATIO,
	// Default identity values are arbitrary
	parameter logic [rilcfg_pkg::WORD_W-1:0]      DEF_VENDOR     = 16'h1234,
	parameter logic [rilcfg_pkg::WORD_W-1:0]      DEF_MODEL      = 16'h0002,
	parameter logic [rilcfg_pkg::WORD_W-1:0]      DEF_SUB_VENDOR = 16'h1234,
	parameter logic [rilcfg_pkg::WORD_W-1:0]      DEF_PRODUCT    = 16'h0001
) (
	input  wire logic                             core_clk_i,
	input  wire logic                             rst_b_i,
	input  wire logic                             soft_reset_i,
	output logic                                  eeprom_serial_clock_o,
	input  wire logic                             eeprom_chip_select_i,
	output logic                                  eeprom_chip_select_o,
	output logic                                  eeprom_chip_select_oe_o,
	output logic                                  eeprom_write_line_o,
	input  wire logic                             eeprom_read_line_i,
	input  wire logic                             port_ctrl_wr_i,
	input  wire rilcfg_pkg::rilcfg_port_wr_t      port_ctrl_wdata_i,
	output rilcfg_pkg::rilcfg_port_rd_t           port_ctrl_rdata_o,
	input  wire logic                             infrared_strap_i,
	input  wire logic                             half_duplex_strap_n_i,
	input  wire logic [1:0]                       mcr_ir_wr_i,
	input  wire logic [1:0]                       mcr_ir_wdata_i,
	input  wire logic [1:0]                       feature_control_reg_hdx_wr_i,
	input  wire logic [1:0]                       feature_control_reg_hdx_wdata_i,
	output logic [1:0]                            mcr_ir_mode_o,
	output logic [1:0]                            feature_control_reg_hdx_mode_o,
	output rilcfg_pkg::rilcfg_id_t                id_words_o,
	output logic                                  id_from_eeprom_o,
	output logic                                  load_busy_o
);

	localparam int unsigned NW = rilcfg_pkg::NUM_WORDS;
	localparam logic [rilcfg_pkg::SENSE_W-1:0] SENSE_LAST =
		rilcfg_pkg::SENSE_W'(rilcfg_pkg::SENSE_CYC - 1);
	localparam logic [rilcfg_pkg::IDX_W-1:0] IDX_LAST = rilcfg_pkg::IDX_W'(NW - 1);

	rilcfg_pkg::rilcfg_state_t           state_reg;
	rilcfg_pkg::rilcfg_state_t           state_next;
	rilcfg_pkg::rilcfg_port_wr_t         man_reg;
	logic [rilcfg_pkg::SENSE_W-1:0]      sense_cnt_reg;
	logic [rilcfg_pkg::IDX_W-1:0]        idx_reg;
	logic [rilcfg_pkg::WORD_W-1:0]       word_reg [NW];
	logic                                present_reg;
	logic                                tick;
	logic                                sense_end;
	logic                                rd_start;
	logic                                rd_sclk;
	logic                                rd_write;
	logic                                rd_busy;
	logic                                rd_done;
	logic [rilcfg_pkg::WORD_W-1:0]       rd_data;

	// Word address for a load index
	function automatic logic [rilcfg_pkg::ADDR_W-1:0] word_addr(
		input logic [rilcfg_pkg::IDX_W-1:0] idx
	);
		case (idx)
			2'h0:    word_addr = rilcfg_pkg::ADDR_VENDOR;
			2'h1:    word_addr = rilcfg_pkg::ADDR_MODEL;
			2'h2:    word_addr = rilcfg_pkg::ADDR_SUB_VENDOR;
			default: word_addr = rilcfg_pkg::ADDR_PRODUCT;
		endcase
	endfunction : word_addr

	rilcfg_tick_div #(
		.DIV (DIV_RATIO)
	) u_div (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.en_i       (state_reg != rilcfg_pkg::ST_SENSE && state_reg != rilcfg_pkg::ST_DONE),
		.tick_o     (tick)
	);

	rilcfg_word_reader u_reader (
		.core_clk_i   (core_clk_i),
		.rst_b_i      (rst_b_i),
		.tick_i       (tick),
		.start_i      (rd_start),
		.addr_i       (word_addr(idx_reg)),
		.read_line_i  (eeprom_read_line_i),
		.sclk_o       (rd_sclk),
		.write_line_o (rd_write),
		.busy_o       (rd_busy),
		.done_o       (rd_done),
		.data_o       (rd_data)
	);

	assign sense_end = state_reg == rilcfg_pkg::ST_SENSE && sense_cnt_reg == SENSE_LAST;
	assign rd_start  = state_reg == rilcfg_pkg::ST_SELECT && tick;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			rilcfg_pkg::ST_SENSE: begin
				if (sense_end) begin
					state_next = eeprom_chip_select_i ? rilcfg_pkg::ST_SELECT
						: rilcfg_pkg::ST_DONE;
				end
			end
			rilcfg_pkg::ST_SELECT: begin
				if (tick) begin
					state_next = rilcfg_pkg::ST_READ;
				end
			end
			rilcfg_pkg::ST_READ: begin
				if (rd_done) begin
					state_next = rilcfg_pkg::ST_GAP;
				end
			end
			rilcfg_pkg::ST_GAP: begin
				if (tick) begin
					state_next = (idx_reg == IDX_LAST) ? rilcfg_pkg::ST_DONE
						: rilcfg_pkg::ST_SELECT;
				end
			end
			rilcfg_pkg::ST_DONE: begin
				state_next = rilcfg_pkg::ST_DONE;
			end
			default: begin
				state_next = rilcfg_pkg::ST_DONE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= rilcfg_pkg::ST_SENSE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sense_cnt_reg <= '0;
			present_reg   <= 1'b0;
		end else if (sense_end) begin
			present_reg <= eeprom_chip_select_i;
		end else if (state_reg == rilcfg_pkg::ST_SENSE) begin
			sense_cnt_reg <= sense_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			idx_reg <= '0;
		end else if (state_reg == rilcfg_pkg::ST_GAP && tick && idx_reg != IDX_LAST) begin
			idx_reg <= idx_reg + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_reg[0] <= DEF_VENDOR;
			word_reg[1] <= DEF_MODEL;
			word_reg[2] <= DEF_SUB_VENDOR;
			word_reg[3] <= DEF_PRODUCT;
		end else if (state_reg == rilcfg_pkg::ST_READ && rd_done) begin
			word_reg[idx_reg] <= rd_data;
		end
	end

	// loaded words only with memory present
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			id_from_eeprom_o <= 1'b0;
		end else if (state_reg == rilcfg_pkg::ST_GAP && tick && idx_reg == IDX_LAST) begin
			id_from_eeprom_o <= present_reg;
		end
	end

	assign id_words_o  = {word_reg[0], word_reg[1], word_reg[2], word_reg[3]};
	assign load_busy_o = state_reg != rilcfg_pkg::ST_DONE;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			man_reg <= '0;
		end else if (port_ctrl_wr_i) begin
			man_reg <= port_ctrl_wdata_i;
		end
	end

	// select driven by loader or software
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			eeprom_serial_clock_o   <= 1'b0;
			eeprom_chip_select_o    <= 1'b0;
			eeprom_chip_select_oe_o <= 1'b0;
			eeprom_write_line_o     <= 1'b0;
		end else if (state_reg == rilcfg_pkg::ST_DONE) begin
			eeprom_serial_clock_o   <= man_reg.clock;
			eeprom_chip_select_o    <= man_reg.select;
			eeprom_chip_select_oe_o <= 1'b1;
			eeprom_write_line_o     <= man_reg.write;
		end else begin
			eeprom_serial_clock_o   <= rd_sclk;
			eeprom_chip_select_o    <= rd_busy || state_reg == rilcfg_pkg::ST_SELECT;
			eeprom_chip_select_oe_o <= state_reg != rilcfg_pkg::ST_SENSE;
			eeprom_write_line_o     <= rd_write;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			port_ctrl_rdata_o <= '0;
		end else begin
			port_ctrl_rdata_o <= {present_reg, load_busy_o, eeprom_read_line_i,
				eeprom_write_line_o, eeprom_chip_select_o, eeprom_serial_clock_o};
		end
	end

	// infrared strap copy, software may rewrite
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mcr_ir_mode_o <= '0;
		end else begin
			for (int ch = 0; ch < 2; ch++) begin
				if (mcr_ir_wr_i[ch]) begin
					mcr_ir_mode_o[ch] <= mcr_ir_wdata_i[ch];
				end else if (sense_end || soft_reset_i) begin
					mcr_ir_mode_o[ch] <= infrared_strap_i;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			feature_control_reg_hdx_mode_o <= '0;
		end else begin
			for (int ch = 0; ch < 2; ch++) begin
				if (feature_control_reg_hdx_wr_i[ch]) begin
					feature_control_reg_hdx_mode_o[ch] <= feature_control_reg_hdx_wdata_i[ch];
				end else if (sense_end) begin
					feature_control_reg_hdx_mode_o[ch] <= half_duplex_strap_n_i;
				end
			end
		end
	end

	a_load_clock_rate: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(rd_sclk != $past(rd_sclk)) |-> $past(tick) && !tick ##1 !tick [*2])
		else $error("serial clock edge not on divider tick");

	a_manual_clock: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(state_reg == rilcfg_pkg::ST_DONE && port_ctrl_wr_i && !$past(port_ctrl_wr_i)) ##1
		!port_ctrl_wr_i |=> eeprom_serial_clock_o == $past(port_ctrl_wdata_i.clock, 2))
		else $error("manual serial clock not applied");

	a_manual_select: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		state_reg == rilcfg_pkg::ST_DONE && port_ctrl_wr_i ##1 !port_ctrl_wr_i
		|=> eeprom_chip_select_o == $past(port_ctrl_wdata_i.select, 2)
			&& eeprom_chip_select_oe_o)
		else $error("manual chip select not applied");

	a_sense_float: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		sense_end |-> !eeprom_chip_select_oe_o ##1 present_reg == $past(eeprom_chip_select_i))
		else $error("select sensed while driven");

	a_manual_write: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		state_reg == rilcfg_pkg::ST_DONE && port_ctrl_wr_i ##1 !port_ctrl_wr_i
		|=> eeprom_write_line_o == $past(port_ctrl_wdata_i.write, 2))
		else $error("manual write line not applied");

	a_read_visible: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		##1 port_ctrl_rdata_o.read_line == $past(eeprom_read_line_i))
		else $error("read line not visible");

	a_ir_strap_copy: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(sense_end || soft_reset_i) && mcr_ir_wr_i == 2'h0
		|=> mcr_ir_mode_o == {2{$past(infrared_strap_i)}})
		else $error("infrared strap not copied");

	a_hdx_strap_copy: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		sense_end && feature_control_reg_hdx_wr_i == 2'h0
		|=> feature_control_reg_hdx_mode_o == {2{$past(half_duplex_strap_n_i)}})
		else $error("half-duplex strap not copied");

	a_hdx_override: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		feature_control_reg_hdx_wr_i[0] |=> feature_control_reg_hdx_mode_o[0] == $past(feature_control_reg_hdx_wdata_i[0]))
		else $error("software half-duplex write lost");

	a_absent_skip: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		sense_end && !eeprom_chip_select_i
		|=> state_reg == rilcfg_pkg::ST_DONE && !id_from_eeprom_o && !rd_busy)
		else $error("load not skipped without memory");

endmodule : rilcfg_loader

// ---- tb/rilcfg_eeprom_model.sv ----
module rilcfg_eeprom_model (
	input  wire logic                   sclk_i,
	input  wire logic                   cs_i,
	input  wire logic                   di_i,
	input  wire rilcfg_pkg::rilcfg_id_t words_i,
	output logic                        do_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0]  cnt;
	logic [7:0]  hdr;
	logic [15:0] wd;
	initial begin
		cnt = 5'h00;
		hdr = 8'h00;
		do_o = 1'b0;
	end
	always @(posedge sclk_i or negedge cs_i) begin
		if (!cs_i) begin
			cnt <= 5'h00;
			// Released line must not keep its last level
			do_o <= ~do_o;
		end else begin
			if (cnt < 5'h19) cnt <= cnt + 5'h01;
			hdr <= {hdr[6:0], di_i};
			if (cnt == 5'h08) begin
				do_o <= 1'b0;
				case ({hdr[7:5] == 3'h6, hdr[4:0], di_i})
					7'h40:   wd <= words_i.vendor;
					7'h41:   wd <= words_i.model;
					7'h42:   wd <= words_i.sub_vendor;
					7'h43:   wd <= words_i.product;
					default: wd <= 16'hffff;
				endcase
			end else if (cnt > 5'h08 && cnt < 5'h19) begin
				do_o <= wd[5'h18 - cnt];
			end
		end
	end
endmodule : rilcfg_eeprom_model

// ---- tb/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned DIV = 8;
	// Default identity values are arbitrary
	localparam logic [63:0] DEFS = 64'h1a2b_3c4d_5e6f_7081;
	logic clk, rst_b, srst, cs_o, cs_oe, sclk, wl, rl_ovr, rl_tb, mem_do;
	logic pres, ir, hdx, pwr, busy, from_ee, cs_line, rl_line;
	logic [1:0] mwr, mwd, fwr, fwd, modem_control_reg, feature_control_reg, e_m, e_f;
	rilcfg_pkg::rilcfg_port_wr_t pwd;
	rilcfg_pkg::rilcfg_port_rd_t prd;
	rilcfg_pkg::rilcfg_id_t      ids, words;
	int failures, num_checks, hi;
	// Pull-up only where a memory is fitted
	assign cs_line = cs_oe ? cs_o : pres;
	assign rl_line = rl_ovr ? rl_tb : mem_do;
	rilcfg_loader #(
		.DIV_RATIO(DIV), .DEF_VENDOR(DEFS[63:48]), .DEF_MODEL(DEFS[47:32]),
		.DEF_SUB_VENDOR(DEFS[31:16]), .DEF_PRODUCT(DEFS[15:0])
	) DUT (
		.core_clk_i(clk), .rst_b_i(rst_b), .soft_reset_i(srst),
		.eeprom_serial_clock_o(sclk), .eeprom_chip_select_i(cs_line),
		.eeprom_chip_select_o(cs_o), .eeprom_chip_select_oe_o(cs_oe),
		.eeprom_write_line_o(wl), .eeprom_read_line_i(rl_line),
		.port_ctrl_wr_i(pwr), .port_ctrl_wdata_i(pwd), .port_ctrl_rdata_o(prd),
		.infrared_strap_i(ir), .half_duplex_strap_n_i(hdx),
		.mcr_ir_wr_i(mwr), .mcr_ir_wdata_i(mwd), .feature_control_reg_hdx_wr_i(fwr),
		.feature_control_reg_hdx_wdata_i(fwd), .mcr_ir_mode_o(modem_control_reg), .feature_control_reg_hdx_mode_o(feature_control_reg),
		.id_words_o(ids), .id_from_eeprom_o(from_ee), .load_busy_o(busy)
	);
	rilcfg_eeprom_model mem (
		.sclk_i(sclk), .cs_i(cs_line), .di_i(wl), .words_i(words), .do_o(mem_do)
	);
	task automatic complete_run;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic chk_bits(string nm, logic [7:0] exp, logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk_bits
	task automatic chk_id(string nm, rilcfg_pkg::rilcfg_id_t exp, rilcfg_pkg::rilcfg_id_t got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk_id
	function automatic rilcfg_pkg::rilcfg_id_t exp_ids(logic p, rilcfg_pkg::rilcfg_id_t w);
		return p ? w : rilcfg_pkg::rilcfg_id_t'(DEFS);
	endfunction : exp_ids
	// Serial clock high time while loading
	always @(posedge clk) begin
		if (!rst_b) begin
			hi <= 0;
		end else if (sclk) begin
			hi <= hi + 1;
		end else begin
			if (hi != 0 && busy) chk_bits("sclk_high", 8'(DIV / 2), hi[7:0]);
			hi <= 0;
		end
	end
	task automatic load_case(logic p, logic i, logic h);
		int n;
		words = {$urandom, $urandom};
		pres = p;
		ir = i;
		hdx = h;
		rl_ovr = 1'b0;
		// Drop select so the memory restarts its command count
		pwr = 1'b1;
		pwd = 3'h0;
		@(negedge clk);
		pwr = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b0;
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		// Manual write while loading must not reach the pins
		pwr = 1'b1;
		pwd = 3'h6;
		@(negedge clk);
		pwr = 1'b0;
		@(negedge clk);
		chk_bits("load_pins", 8'h00, {4'h0, sclk, cs_o, cs_oe, wl});
		n = 0;
		while (busy !== 1'b0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20000) begin
			failures++;
			complete_run();
		end
		e_m = {i, i};
		e_f = {h, h};
		chk_id("ids", exp_ids(p, words), ids);
		chk_bits("from_ee", {7'h0, p}, {7'h0, from_ee});
		chk_bits("mcr", {6'h0, e_m}, {6'h0, modem_control_reg});
		chk_bits("feature_control_reg", {6'h0, e_f}, {6'h0, feature_control_reg});
	endtask : load_case
	task automatic port_case(logic [2:0] v, logic r);
		pwr = 1'b1;
		pwd = v;
		rl_ovr = 1'b1;
		rl_tb = r;
		@(negedge clk);
		pwr = 1'b0;
		repeat (3) @(negedge clk);
		chk_bits("sclk", {7'h0, v[2]}, {7'h0, sclk});
		chk_bits("sel", {6'h0, v[1], 1'b1}, {6'h0, cs_o, cs_oe});
		chk_bits("wl", {7'h0, v[0]}, {7'h0, wl});
		chk_bits("rdata", {2'h0, pres, 1'b0, r, v[0], v[1], v[2]}, {2'h0, prd});
	endtask : port_case
	task automatic sw_case;
		logic n;
		mwr = 2'($urandom);
		mwd = 2'($urandom);
		fwr = 2'($urandom);
		fwd = 2'($urandom);
		n = 1'($urandom);
		e_m = (mwr & mwd) | (~mwr & e_m);
		e_f = (fwr & fwd) | (~fwr & e_f);
		@(negedge clk);
		mwr = 2'h0;
		fwr = 2'h0;
		@(negedge clk);
		chk_bits("mcr_sw", {6'h0, e_m}, {6'h0, modem_control_reg});
		chk_bits("feature_control_reg_sw", {6'h0, e_f}, {6'h0, feature_control_reg});
		ir = n;
		hdx = ~hdx;
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk_bits("mcr_srst", {6'h0, n, n}, {6'h0, modem_control_reg});
		e_m = {n, n};
		chk_bits("feature_control_reg_srst", {6'h0, e_f}, {6'h0, feature_control_reg});
	endtask : sw_case
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#1ms;
		failures++;
		complete_run();
	end
	initial begin
		{rst_b, srst, pwr, rl_ovr, rl_tb, pres, ir, hdx} = 8'h00;
		{mwr, mwd, fwr, fwd} = 8'h00;
		pwd = 3'h0;
		words = 64'h0;
		void'($urandom(32'hf2e4));
		for (int i = 0; i < 4; i++) begin
			load_case(i != 3, i[0], i[1]);
			port_case(3'h7, 1'b1);
			port_case(3'h0, 1'b0);
			repeat (3) port_case(3'($urandom), 1'($urandom));
			repeat (2) sw_case();
		end
		complete_run();
	end
endmodule : tb
